// >>> logic/reset_cause_pkg.sv
/*
 * Constants for the reset cause recorder: register address, flag bit
 * positions, reset values, the trapping opcode and reset stretch timing.
 * Assumes a 10 MHz system clock and a 20-bit CPU byte address space.
 */
package reset_cause_pkg;

    // CPU address space and the cause register
    localparam int          ADDR_W            = 20;
    localparam int          DATA_W            = 8;
    localparam logic [19:0] CAUSE_ADDR        = 20'hfffa8;

    // Flag bit positions in reset_cause_flags
    localparam int          BIT_BAD_OPCODE    = 7;
    localparam int          BIT_WATCHDOG      = 4;
    localparam int          BIT_RAM_PARITY    = 2;
    localparam int          BIT_BAD_ACCESS    = 1;
    localparam int          BIT_LOW_VOLTAGE   = 0;

    // Reset values
    localparam logic [7:0]  FLAGS_RESET       = 8'h00;
    localparam logic        PARITY_DIS_RESET  = 1'b0;
    localparam logic [7:0]  READ_IDLE         = 8'h00;

    // Instruction byte that raises a trap reset
    localparam logic [7:0]  BAD_OPCODE        = 8'hff;

    // Internal reset stretch: time in ns, then cycles at the system rate
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          RESET_HOLD_NS     = 1600;
    localparam int          RESET_HOLD_CYC    = (RESET_HOLD_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
    localparam int          HOLD_W            = 8;

    // Whole block state, registered in one place
    typedef struct packed {
        logic [2:0]         extSync;      // Reset pin synchroniser
        logic [2:0]         fallSync;     // Fall comparator synchroniser
        logic [2:0]         riseSync;     // Rise comparator synchroniser
        logic               extLevel;     // Filtered pin level
        logic               fallLevel;    // Filtered fall comparator
        logic               riseLevel;    // Filtered rise comparator
        logic               porActive;    // Power-on reset held
        logic [7:0]         flags;        // Cause flags
        logic               parityDis;    // Parity reset disable
        logic [HOLD_W-1:0]  holdCnt;      // Internal reset stretch
        logic               resetOut;     // Internal reset to the chip
        logic [7:0]         rdData;       // Read answer
        logic               rdValid;      // Read answer strobe
    } state_t;

endpackage : reset_cause_pkg

// >>> logic/reset_cause_recorder.sv
/*
 * Reset cause recorder: keeps sticky flags naming the sources of all
 * internal resets since the last clear, answers CPU byte reads of the cause register
 * and clears it on such a read, runs the power-on reset hold from the
 * two supply comparators and stretches internal reset requests.
 * Assumes rst_b is the block's own power-up reset, that the reset pin
 * and comparator outputs are asynchronous, and that the CPU and the
 * reset sources run on clk_sys.
 */
`timescale 1ns/1ns

module reset_cause_recorder #(
    parameter int HOLD_CYC = reset_cause_pkg::RESET_HOLD_CYC  // Internal reset stretch
) (
    input  wire logic        clk_sys,            // System clock, 10 MHz
    input  wire logic        rst_b,              // Block power-up reset, low
    input  wire logic        resetPin_b,         // External reset pin, async, low
    input  wire logic        supplyBelowFall,    // Fall comparator, async
    input  wire logic        supplyAboveRise,    // Rise comparator, async
    input  wire logic        opcodeExec,         // Instruction executed strobe
    input  wire logic [7:0]  opcodeByte,         // Its first code byte
    input  wire logic        debugEmulation,     // Debug emulator in control
    input  wire logic        watchdogReq,        // Watchdog reset request
    input  wire logic        parityErrReq,       // RAM parity error seen
    input  wire logic        badAccessReq,       // Illegal memory access seen
    input  wire logic        voltageMonitorReq,  // Voltage monitor reset request
    input  wire logic        parityDisWr,        // Write strobe for disable bit
    input  wire logic        parityDisData,      // Value to write
    input  wire logic [19:0] cpuAddr,            // CPU byte address
    input  wire logic        cpuRead,            // CPU read strobe
    input  wire logic        cpuByteAccess,      // Read is a full byte access
    output logic [7:0]       cpuReadData,        // Read answer data
    output logic             cpuReadValid,       // Read answer strobe
    output logic             internalReset,      // Chip reset, high active
    output logic             parityResetDisable  // Parity reset disable bit
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Latency at a glance, counted in clk_sys edges
    // - read strobe taken at edge n: answer stands from edge n to edge n+1
    // - source request taken at edge n: flag and internalReset show from n,
    //   internalReset stands HOLD_CYC cycles counted from the edge of the last request
    // - pin change: filtered level on the fourth edge, internalReset on the
    //   fifth; a comparator change adds one edge for the power-on latch
    // - flag set and clearing read on one edge: the set wins, so a cause
    //   raised during a read is kept for the next read, never lost
    // - parity disable forced low on any edge with a reset active, so a
    //   write in that window is lost

    // Address decode for the cause register
    function automatic logic hitCause(input logic [19:0] addr);
        hitCause = (addr == reset_cause_pkg::CAUSE_ADDR);
    endfunction : hitCause

    // Second and third stages agree: the new level counts
    // Two agreeing stages reject a single-cycle glitch on the pin
    function automatic logic filterLevel(input logic [2:0] sync, input logic prev);
        filterLevel = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction : filterLevel

    // Load value for the stretch counter, cut to its width on purpose
    localparam logic [reset_cause_pkg::HOLD_W-1:0] HOLD_LOAD =
        reset_cause_pkg::HOLD_W'(HOLD_CYC);

    // Whole-block state and its next value
    reset_cause_pkg::state_t stateQ;
    reset_cause_pkg::state_t stateD;

    // Decoded requests and read strobes
    logic       trapSeen;
    logic       trapReq;
    logic       parityReq;
    logic       anyInternal;
    logic       clearAll;
    logic       readHit;
    logic       readClear;
    logic [7:0] setMask;

    ////////////////////////////////////////////////////////////////////////
    // Source qualification

    // Illegal code byte seen, before the emulator mask
    assign trapSeen  = opcodeExec && (opcodeByte == reset_cause_pkg::BAD_OPCODE);
    // Trap is suppressed while an emulator owns the core
    assign trapReq   = trapSeen && !debugEmulation;
    // Parity errors only reset while enabled
    assign parityReq = parityErrReq && !stateQ.parityDis;

    // Cause register decode, shared by the answer and the clear
    assign readHit   = cpuRead && hitCause(cpuAddr);
    // Bit reads leave the flags alone; only a byte read clears
    assign readClear = readHit && cpuByteAccess;

    // One bit per source; reserved bits never set
    always_comb begin
        setMask = 8'h00;
        setMask[reset_cause_pkg::BIT_BAD_OPCODE]  = trapReq;
        setMask[reset_cause_pkg::BIT_WATCHDOG]    = watchdogReq;
        setMask[reset_cause_pkg::BIT_RAM_PARITY]  = parityReq;
        setMask[reset_cause_pkg::BIT_BAD_ACCESS]  = badAccessReq;
        setMask[reset_cause_pkg::BIT_LOW_VOLTAGE] = voltageMonitorReq;
    end

    assign anyInternal = |setMask;
    // Pin low or power-on held clears the flags and the parity disable bit
    // Levels, not edges: the flags stay clear for as long as either holds
    assign clearAll    = !stateQ.extLevel || stateQ.porActive;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        stateD = stateQ;

        // Three-stage synchronisers; first stage feeds only the second
        stateD.extSync  = {stateQ.extSync[1:0], resetPin_b};
        stateD.fallSync = {stateQ.fallSync[1:0], supplyBelowFall};
        stateD.riseSync = {stateQ.riseSync[1:0], supplyAboveRise};
        stateD.extLevel  = filterLevel(stateQ.extSync, stateQ.extLevel);
        stateD.fallLevel = filterLevel(stateQ.fallSync, stateQ.fallLevel);
        stateD.riseLevel = filterLevel(stateQ.riseSync, stateQ.riseLevel);

        // Hysteresis: fall sets, rise releases, fall wins if both show
        // A supply dipping under the fall threshold must reset even if the
        // rise comparator has not yet dropped, so fall takes priority
        if (stateQ.fallLevel) begin
            stateD.porActive = 1'b1;
        end else if (stateQ.riseLevel) begin
            stateD.porActive = 1'b0;
        end

        // Read answer; data is the value before any clear
        // Unmapped reads still answer, with the idle value
        stateD.rdValid = cpuRead;
        stateD.rdData  = reset_cause_pkg::READ_IDLE;
        if (readHit) begin
            stateD.rdData = stateQ.flags;
        end

        // Flags: full clear first, then a set beats the read clear
        if (clearAll) begin
            stateD.flags = reset_cause_pkg::FLAGS_RESET;
        end else begin
            if (readClear) begin
                stateD.flags = reset_cause_pkg::FLAGS_RESET;
            end
            // Internal sources OR in, the rest stays as it was
            stateD.flags = stateD.flags | setMask;
        end

        // Disable bit written by its owner, forced low by any reset
        // Reset wins over a write in the same cycle
        if (parityDisWr) begin
            stateD.parityDis = parityDisData;
        end
        if (clearAll || anyInternal || stateQ.resetOut) begin
            stateD.parityDis = reset_cause_pkg::PARITY_DIS_RESET;
        end

        // Stretch each internal request so the core sees a full pulse
        // The counter is reloaded by every request, so back-to-back causes
        // extend one pulse rather than chopping it into pieces
        if (anyInternal) begin
            stateD.holdCnt = HOLD_LOAD;
        end else if (stateQ.holdCnt != '0) begin
            stateD.holdCnt = stateQ.holdCnt - 1'b1;
        end
        stateD.resetOut = clearAll || anyInternal || (stateQ.holdCnt > 1);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Power-up holds the chip in reset until the comparators are seen
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // Idle levels: pin high, comparators quiet, no false change
            stateQ.extSync   <= 3'h7;
            stateQ.fallSync  <= 3'h0;
            stateQ.riseSync  <= 3'h0;
            stateQ.extLevel  <= 1'b1;
            stateQ.fallLevel <= 1'b0;
            stateQ.riseLevel <= 1'b0;
            stateQ.porActive <= 1'b1;
            stateQ.flags     <= reset_cause_pkg::FLAGS_RESET;
            stateQ.parityDis <= reset_cause_pkg::PARITY_DIS_RESET;
            stateQ.holdCnt   <= '0;
            stateQ.resetOut  <= 1'b1;
            stateQ.rdData    <= reset_cause_pkg::READ_IDLE;
            stateQ.rdValid   <= 1'b0;
        end else begin
            stateQ <= stateD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Outputs straight from flops; no logic between register and pin
    assign cpuReadData        = stateQ.rdData;
    assign cpuReadValid       = stateQ.rdValid;
    assign internalReset      = stateQ.resetOut;
    assign parityResetDisable = stateQ.parityDis;

endmodule : reset_cause_recorder

// >>> tb/cpu_bus_model.sv
/* CPU side model issuing single reads of the cause register or any other address.
   Assumes each call starts at a falling edge of clk_sys. */
`timescale 1ns/1ns
module cpu_bus_model (
    input  wire logic        clk_sys,       // System clock
    input  wire logic [7:0]  cpuReadData,   // Answer data
    output logic             cpuRead,       // Read strobe
    output logic [19:0]      cpuAddr,       // Byte address
    output logic             cpuByteAccess  // Byte-wide access
);
    initial cpuRead = 1'b0;
    initial cpuAddr = 20'h00000;
    initial cpuByteAccess = 1'b1;
    // Strobe for one edge, answer taken while it stands, then one idle edge
    task automatic rd(input logic [19:0] a, input logic byteAcc, output logic [7:0] d);
        cpuRead = 1'b1;
        cpuAddr = a;
        cpuByteAccess = byteAcc;
        @(negedge clk_sys);
        d = cpuReadData;
        cpuRead = 1'b0;
        cpuAddr = ~a; // Released bus must not look like a hit
        @(negedge clk_sys);
    endtask : rd
endmodule : cpu_bus_model

// >>> tb/reset_cause_recorder_chk.sv
/* Checker for the reset cause recorder: read answer timing, reserved bits,
   read clear and reset raising. Assumes a bind onto the design top. */
`timescale 1ns/1ns
module reset_cause_recorder_chk (
    input wire logic        clk_sys,            // Clock
    input wire logic        rst_b,              // Block reset, low
    input wire logic        resetPin_b,         // Reset pin, low
    input wire logic        supplyBelowFall,    // Fall comparator
    input wire logic        opcodeExec,         // Instruction strobe
    input wire logic [7:0]  opcodeByte,         // Code byte
    input wire logic        debugEmulation,     // Emulator in control
    input wire logic        watchdogReq,        // Watchdog request
    input wire logic        parityErrReq,       // Parity request
    input wire logic        badAccessReq,       // Access request
    input wire logic        voltageMonitorReq,  // Voltage request
    input wire logic [19:0] cpuAddr,            // CPU address
    input wire logic        cpuRead,            // Read strobe
    input wire logic        cpuByteAccess,      // Byte access
    input wire logic [7:0]  cpuReadData,        // Read data
    input wire logic        cpuReadValid,       // Read valid
    input wire logic        internalReset,      // Chip reset
    input wire logic        parityResetDisable  // Disable bit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    // Any event that could set a flag and mask a read clear
    wire anyReq = watchdogReq | parityErrReq | badAccessReq | voltageMonitorReq | opcodeExec;
    sequence clearRd;
        cpuRead && cpuByteAccess && cpuAddr == reset_cause_pkg::CAUSE_ADDR && !anyReq;
    endsequence
    sequence hitRd;
        cpuRead && cpuAddr == reset_cause_pkg::CAUSE_ADDR && resetPin_b;
    endsequence
    chk_read_answer: assert property (cpuRead |=> cpuReadValid)
        else $error("read not answered");
    chk_no_stray: assert property (!cpuRead |=> !cpuReadValid)
        else $error("answer without read");
    chk_reserved_zero: assert property (cpuReadValid |-> (cpuReadData & 8'h68) == 8'h00)
        else $error("reserved bits set");
    chk_read_clears: assert property (clearRd ##1 !anyReq ##1 clearRd |=> cpuReadData == 8'h00)
        else $error("flags survive byte read");
    chk_trap_reset: assert property (opcodeExec && opcodeByte == 8'hff && !debugEmulation |=> internalReset)
        else $error("trap gave no reset");
    chk_wdog_reset: assert property (watchdogReq |=> internalReset && !parityResetDisable)
        else $error("watchdog reset wrong");
    chk_wdog_flag: assert property (watchdogReq ##1 hitRd |=> cpuReadData[4])
        else $error("watchdog flag missing");
    chk_pin_hold: assert property (!resetPin_b [*7] |-> internalReset)
        else $error("pin gave no reset");
    chk_por_hold: assert property (supplyBelowFall [*7] |-> internalReset)
        else $error("low supply gave no reset");
endmodule : reset_cause_recorder_chk
bind reset_cause_recorder reset_cause_recorder_chk chk (.clk_sys, .rst_b, .resetPin_b,
    .supplyBelowFall, .opcodeExec, .opcodeByte, .debugEmulation, .watchdogReq, .parityErrReq,
    .badAccessReq, .voltageMonitorReq, .cpuAddr, .cpuRead, .cpuByteAccess, .cpuReadData,
    .cpuReadValid, .internalReset, .parityResetDisable);

// >>> tb/reset_cause_recorder_tb_top.sv
/* Testbench for the reset cause recorder: sources, pin and comparators driven
   at the falling edge, register read through the CPU model; checker bound in. */
`timescale 1ns/1ns
module reset_cause_recorder_tb_top;
    localparam logic [19:0] A = reset_cause_pkg::CAUSE_ADDR;
    logic clk_sys = 1'b0, rst_b = 1'b0, resetPin_b = 1'b1, below = 1'b0, above = 1'b1;
    logic opcodeExec = 1'b0, debugEmulation = 1'b0, parityDisWr = 1'b0, parityDisData = 1'b0;
    logic [3:0] req = 4'h0;
    logic [7:0] opcodeByte = 8'hff;
    logic [19:0] cpuAddr;
    logic cpuRead, cpuByteAccess, cpuReadValid, internalReset, parityResetDisable;
    logic [7:0] cpuReadData, rdv;
    int errors = 0, n_checks = 0, cyc = 0;
    int pos[5] = '{reset_cause_pkg::BIT_WATCHDOG, reset_cause_pkg::BIT_RAM_PARITY,
        reset_cause_pkg::BIT_BAD_ACCESS, reset_cause_pkg::BIT_LOW_VOLTAGE, reset_cause_pkg::BIT_BAD_OPCODE};
    reset_cause_recorder #(.HOLD_CYC(3)) dut (.clk_sys, .rst_b, .resetPin_b,
        .supplyBelowFall(below), .supplyAboveRise(above), .opcodeExec, .opcodeByte,
        .debugEmulation, .watchdogReq(req[0]), .parityErrReq(req[1]), .badAccessReq(req[2]),
        .voltageMonitorReq(req[3]), .parityDisWr, .parityDisData, .cpuAddr, .cpuRead,
        .cpuByteAccess, .cpuReadData, .cpuReadValid, .internalReset, .parityResetDisable);
    cpu_bus_model cpu (.clk_sys, .cpuReadData, .cpuRead, .cpuAddr, .cpuByteAccess);
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; a full run takes under a hundred cycles
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            test_done();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    // One cycle request from source k, 4 being the trapping opcode
    // Parity pulses stand for errors in RAM that software has initialised
    task automatic fire(input int k);
        if (k < 4) req[k] = 1'b1;
        else opcodeExec = 1'b1;
        @(negedge clk_sys);
        if (k < 4) req[k] = 1'b0;
        else opcodeExec = 1'b0;
        check("reset raised", {7'h00, internalReset}, 8'h01);
    endtask : fire
    task automatic settle;
        for (int i = 0; i < 40 && internalReset !== 1'b0; i++) @(negedge clk_sys);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_sources;
        logic [7:0] exp;
        exp = 8'h00;
        for (int k = 0; k < 5; k++) begin
            fire(k);
            exp |= 8'h01 << pos[k];
        end
        cpu.rd(A, 1'b1, rdv);
        check("all flags", rdv, exp);
        cpu.rd(A, 1'b1, rdv);
        check("flags cleared", rdv, 8'h00);
    endtask : test_sources
    task automatic test_debug_disable;
        settle();
        opcodeByte = 8'h00;
        opcodeExec = 1'b1;
        @(negedge clk_sys);
        opcodeExec = 1'b0;
        opcodeByte = 8'hff;
        check("other opcode", {7'h00, internalReset}, 8'h00);
        @(negedge clk_sys);
        debugEmulation = 1'b1;
        opcodeExec = 1'b1;
        @(negedge clk_sys);
        opcodeExec = 1'b0;
        debugEmulation = 1'b0;
        parityDisWr = 1'b1;
        parityDisData = 1'b1;
        check("no trap reset", {7'h00, internalReset}, 8'h00);
        @(negedge clk_sys);
        parityDisWr = 1'b0;
        check("disable set", {7'h00, parityResetDisable}, 8'h01);
        req[1] = 1'b1;
        @(negedge clk_sys);
        req[1] = 1'b0;
        check("parity masked", {7'h00, internalReset}, 8'h00);
        fire(0);
        check("disable forced", {7'h00, parityResetDisable}, 8'h00);
        cpu.rd(A, 1'b1, rdv);
        check("watchdog only", rdv, 8'h01 << pos[0]);
    endtask : test_debug_disable
    task automatic test_bus;
        fire(2);
        cpu.rd(A, 1'b0, rdv);
        check("bit read", rdv, 8'h01 << pos[2]);
        cpu.rd(20'h00000, 1'b1, rdv);
        check("unmapped", rdv, 8'h00);
        cpu.rd(A, 1'b1, rdv);
        check("kept flag", rdv, 8'h01 << pos[2]);
    endtask : test_bus
    task automatic test_pin_por;
        fire(3);
        cpu.rd(A, 1'b1, rdv);
        check("low voltage only", rdv, 8'h01 << pos[3]);
        fire(3);
        settle();
        resetPin_b = 1'b0;
        repeat (8) @(negedge clk_sys);
        check("pin reset", {7'h00, internalReset}, 8'h01);
        resetPin_b = 1'b1;
        settle();
        cpu.rd(A, 1'b1, rdv);
        check("pin cleared", rdv, 8'h00);
        fire(1);
        below = 1'b1;
        above = 1'b0;
        repeat (8) @(negedge clk_sys);
        check("por reset", {7'h00, internalReset}, 8'h01);
        below = 1'b0;
        above = 1'b1;
        settle();
        check("por released", {7'h00, internalReset}, 8'h00);
        cpu.rd(A, 1'b1, rdv);
        check("por cleared", rdv, 8'h00);
    endtask : test_pin_por
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        settle();
        test_sources();
        test_debug_disable();
        test_bus();
        test_pin_por();
        test_done();
    end
endmodule : reset_cause_recorder_tb_top
